// ### design/fvr_consts.vh
// Constants for the field region register bank: offsets, field positions, reset values.
// Assumes inclusion by name from design files; holds definitions only.
`ifndef FVR_CONSTS_VH
`define FVR_CONSTS_VH
`define FVR_ADDR_W 4
`define FVR_DATA_W 26
`define FVR_OFF_SEQ_LO 4'h0
`define FVR_OFF_SEQ_HI 4'h1
`define FVR_OFF_LAST_MODES 4'h2
`define FVR_OFF_SCP01 4'h3
`define FVR_OFF_SCP23 4'h4
`define FVR_OFF_SCP45 4'h5
`define FVR_OFF_SCP6 4'h6
`define FVR_OFF_SCP78_LEN 4'h7
`define FVR_OFF_CTRL 4'h8
`define FVR_OFF_STATUS 4'h9
`define FVR_SEQ_W 5
`define FVR_MS_W 2
`define FVR_POS_W 13
`define FVR_LO_POS 0
`define FVR_HI_POS 13
`define FVR_HI_MS_POS 20
`define FVR_LAST_MS_POS 13
`define FVR_LAST_MSB_POS 25
`define FVR_CTRL_H14_POS 0
`define FVR_CTRL_RUN_POS 1
`define FVR_RST_WORD 26'h0000000
`define FVR_RST_LEN 13'h0106
`define FVR_RST_LINE 14'h0800
`endif

// ### design/fvr_field_regs.v
// Field region register bank with field timing: staged registers, line/field counters,
// region tracking and per-region sequence/multiplier/sweep outputs.
// Assumes a plain register port with read data one cycle after the read strobe.
// Function
// - Each of nine regions plays the sequence given by its own 5-bit select.
// - Mode code 0 none, 1 sweep only, 2 multiplier only, 3 both.
// - Each region has its own 2-bit mode; regions three to eight in word two.
// - Last line of each field uses the programmed last-line length.
// - With 14-bit counter enabled, bit 25 of word two is length MSB.
// - Thirteen-bit change lines, two per word, advance the region sequence.
// - Lines are counted from 0 up to one below the programmed field length each field.
`timescale 1ns/1ns
`include "fvr_consts.vh"
module fvr_field_regs #(
   parameter REGIONS = 9,
   parameter LINE_W = 14
) (
   input wire clk,
   input wire rst,
   input wire [`FVR_ADDR_W-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   output reg [4:0] region_sequence_select,
   output reg [3:0] region_index,
   output reg mult_on,
   output reg sweep_on,
   output reg [12:0] line_number,
   output reg horizontal_drive_line_sync,
   output reg vertical_drive_field_sync
);
////////////////////////////////////////////////////////////////////////////////
// Staged (software) and active (field) copies
reg [25:0] stg_r [0:7];
reg [25:0] act_r [0:7];
reg h14_r;
reg run_r;
reg pend_r;
integer i;
integer j;
wire field_end;
////////////////////////////////////////////////////////////////////////////////
// Words 0 to 7 wait for the field boundary while running, else load next cycle; ctrl and status act at once
function is_fld_word;
   input [3:0] a;
   begin
      is_fld_word = (a <= `FVR_OFF_SCP78_LEN);
   end
endfunction
always @(posedge clk)
begin
   if (rst)
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         stg_r[i] <= `FVR_RST_WORD;
      end
      stg_r[7] <= {`FVR_RST_LEN, 13'h1FFF};
      h14_r <= 1'b0;
      run_r <= 1'b0;
      pend_r <= 1'b0;
   end
   else
   begin
      if (wr && is_fld_word(addr))
      begin
         stg_r[addr[2:0]] <= wdata[25:0];
      end
      if (wr && addr == `FVR_OFF_CTRL)
      begin
         h14_r <= wdata[`FVR_CTRL_H14_POS];
         run_r <= wdata[`FVR_CTRL_RUN_POS];
      end
      // Set wins over the boundary clear so a late write is never dropped
      if (wr && is_fld_word(addr))
         pend_r <= 1'b1;
      else if (field_end || !run_r)
         pend_r <= 1'b0;
   end
end
always @(posedge clk)
begin
   if (rst)
   begin
      for (j = 0; j < 8; j = j + 1)
      begin
         act_r[j] <= `FVR_RST_WORD;
      end
      act_r[7] <= {`FVR_RST_LEN, 13'h1FFF};
   end
   else if (field_end || !run_r)
   begin
      for (j = 0; j < 8; j = j + 1)
      begin
         act_r[j] <= stg_r[j];
      end
   end
end
////////////////////////////////////////////////////////////////////////////////
// Field decode helpers
function [4:0] seq_of;
   input [3:0] r;
   input [25:0] lo;
   input [25:0] hi;
   begin
      if (r < 4'h5)
         seq_of = lo[r*5 +: 5];
      else
         seq_of = hi[(r-4'h5)*5 +: 5];
   end
endfunction
function [1:0] ms_of;
   input [3:0] r;
   input [25:0] hi;
   input [25:0] w2;
   begin
      // Regions 1 and 2 follow their bit order, not the swapped labels
      if (r < 4'h3)
         ms_of = hi[`FVR_HI_MS_POS + r*2 +: 2];
      else
         ms_of = w2[`FVR_LAST_MS_POS + (r-4'h3)*2 +: 2];
   end
endfunction
function [12:0] scp_of;
   input [3:0] k;
   input [25:0] w3;
   input [25:0] w4;
   input [25:0] w5;
   input [25:0] w6;
   input [25:0] w7;
   reg [25:0] w;
   begin
      w = 26'h0000000;
      case (k[3:1])
         3'h0: w = w3;
         3'h1: w = w4;
         3'h2: w = w5;
         3'h3: w = w6;
         default: w = w7;
      endcase
      scp_of = k[0] ? w[`FVR_HI_POS +: 13] : w[`FVR_LO_POS +: 13];
   end
endfunction
////////////////////////////////////////////////////////////////////////////////
// Line and field counting
wire [12:0] fld_len = act_r[7][`FVR_HI_POS +: 13];
wire [12:0] max_line = (fld_len == 13'h0000) ? 13'h0000 : fld_len - 13'h0001;
wire last_line = (line_number >= max_line);
// Only 13 bits are used unless the wide counter is enabled
wire [13:0] last_len = {h14_r & act_r[2][`FVR_LAST_MSB_POS], act_r[2][12:0]};
wire [LINE_W-1:0] cur_len = last_line ? last_len[LINE_W-1:0] : `FVR_RST_LINE;
wire line_end;
assign field_end = line_end && last_line;
fvr_line_timer #(.W(LINE_W)) u_timer (
   .clk(clk),
   .rst(rst),
   .en(run_r),
   .len(cur_len),
   .line_end(line_end)
);
wire [12:0] next_scp = scp_of(region_index, act_r[3], act_r[4], act_r[5], act_r[6], act_r[7]);
reg [3:0] reg_nxt;
always @*
begin
   reg_nxt = region_index;
   if (field_end)
      reg_nxt = 4'h0;
   else if (line_end && region_index < REGIONS - 1 &&
            line_number + 13'h0001 == next_scp && next_scp <= max_line)
      reg_nxt = region_index + 4'h1;
end
wire [1:0] ms_nxt = ms_of(reg_nxt, act_r[1], act_r[2]);
always @(posedge clk)
begin
   if (rst || !run_r)
   begin
      line_number <= 13'h0000;
      region_index <= 4'h0;
      horizontal_drive_line_sync <= 1'b0;
      vertical_drive_field_sync <= 1'b0;
      region_sequence_select <= 5'h00;
      mult_on <= 1'b0;
      sweep_on <= 1'b0;
   end
   else
   begin
      horizontal_drive_line_sync <= line_end;
      vertical_drive_field_sync <= field_end;
      if (field_end)
         line_number <= 13'h0000;
      else if (line_end)
         line_number <= line_number + 13'h0001;
      region_index <= reg_nxt;
      region_sequence_select <= seq_of(reg_nxt, act_r[0], act_r[1]);
      mult_on <= ms_nxt[1];
      sweep_on <= ms_nxt[0];
   end
end
////////////////////////////////////////////////////////////////////////////////
// Read port: staged values read back; status shows live position
always @(posedge clk)
begin
   if (rst)
      rdata <= 32'h00000000;
   else if (rd)
   begin
      if (is_fld_word(addr))
         rdata <= {6'h00, stg_r[addr[2:0]]};
      else if (addr == `FVR_OFF_CTRL)
         rdata <= {30'h00000000, run_r, h14_r};
      else if (addr == `FVR_OFF_STATUS)
         rdata <= {14'h0000, pend_r, region_index, line_number};
      else
         rdata <= 32'h00000000;
   end
   else
      rdata <= 32'h00000000;
end
endmodule

// ### design/fvr_line_timer.v
// Line timer: counts clock cycles within a line and pulses at each line end.
// Assumes the length input is stable during the line; a length of 0 is taken as 1.
`timescale 1ns/1ns
module fvr_line_timer #(
   parameter W = 14
) (
   input wire clk,
   input wire rst,
   input wire en,
   input wire [W-1:0] len,
   output reg line_end
);
reg [W-1:0] cnt_r;
always @(posedge clk)
begin
   if (rst || !en)
   begin
      cnt_r <= {W{1'b0}};
      line_end <= 1'b0;
   end
   else if (cnt_r + {{(W-1){1'b0}}, 1'b1} >= len)
   begin
      cnt_r <= {W{1'b0}};
      line_end <= 1'b1;
   end
   else
   begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      line_end <= 1'b0;
   end
end
endmodule

// ### verification/fvr_field_regs_monitor.sv
// Checker on the ports of the field region bank.
// Assumes one clock, synchronous reset, bound to fvr_field_regs.
`timescale 1ns/1ns
module fvr_monitor (
   input wire clk,
   input wire rst,
   input wire [3:0] addr,
   input wire rd,
   input wire [31:0] rdata,
   input wire [3:0] region_index,
   input wire [12:0] line_number,
   input wire horizontal_drive_line_sync,
   input wire vertical_drive_field_sync
);
   wire h = horizontal_drive_line_sync;
   wire v = vertical_drive_field_sync;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata set without read");
   property p_rd_void; rd && addr > 4'h9 |=> rdata == 32'h0; endproperty
   a_rd_void: assert property (p_rd_void) else $error("unmapped read not zero");
   property p_rg_max; region_index <= 4'h8; endproperty
   a_rg_max: assert property (p_rg_max) else $error("region above eight");
   // Line and region move only on the edge that also raises the line pulse
   property p_ln_step; $changed(line_number) |-> h; endproperty
   a_ln_step: assert property (p_ln_step) else $error("line moved off line end");
   property p_ln_inc;
      $changed(line_number) |-> line_number == $past(line_number) + 13'h1 || line_number == 13'h0;
   endproperty
   a_ln_inc: assert property (p_ln_inc) else $error("line skipped");
   property p_rg_step; $changed(region_index) |-> h; endproperty
   a_rg_step: assert property (p_rg_step) else $error("region moved off line end");
   property p_rg_inc;
      $changed(region_index) |-> region_index == $past(region_index) + 4'h1 || region_index == 4'h0;
   endproperty
   a_rg_inc: assert property (p_rg_inc) else $error("region skipped");
   property p_fld_top; v |-> ##[0:2] line_number == 13'h0; endproperty
   a_fld_top: assert property (p_fld_top) else $error("field end without line zero");
   c_field: cover property (v);
   c_line1: cover property (h ##1 line_number == 13'h1);
   c_void: cover property (rd && addr == 4'hC);
endmodule
bind fvr_field_regs fvr_monitor u_mon (.clk(clk), .rst(rst), .addr(addr), .rd(rd),
   .rdata(rdata), .region_index(region_index), .line_number(line_number),
   .horizontal_drive_line_sync(horizontal_drive_line_sync),
   .vertical_drive_field_sync(vertical_drive_field_sync));

// ### verification/fvr_field_regs_tb_top.sv
// Testbench for the field region bank: register table, region walk, field timing.
// Assumes the fixed normal line of 0x800 cycles and staging while running.
`timescale 1ns/1ns
module fvr_field_regs_tb_top;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [3:0] addr = 4'h0;
   reg [31:0] wdata = 32'h0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   wire [31:0] rdata;
   wire [4:0] sel;
   wire [3:0] rgn;
   wire [12:0] ln;
   wire mul, swp, hs, vs;
   integer error_cnt = 0;
   integer num_checks = 0;
   integer cyc = 0;
   integer i, t0;
   reg [35:0] rows [0:7];
   // Per region {select, mult, sweep}: all four mode codes appear
   reg [27:0] exv = {7'h28, 7'h7F, 7'h46, 7'h0D};
   fvr_field_regs dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .region_sequence_select(sel), .region_index(rgn), .mult_on(mul),
      .sweep_on(swp), .line_number(ln), .horizontal_drive_line_sync(hs),
      .vertical_drive_field_sync(vs));
   initial forever #10 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 70000)
      begin
         error_cnt = error_cnt + 1;
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task wr_reg(input [3:0] a, input [31:0] d);
   begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   end
   endtask
   task rd_reg(input [3:0] a, input [31:0] e);
   begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   end
   endtask
   // Bounded only by the global cycle ceiling
   task wait_sync(input fld);
   begin
      @(posedge clk) #1;
      while ((fld ? vs : hs) !== 1'b1)
         @(posedge clk) #1;
   end
   endtask
   task after_rst;
   begin
      @(posedge clk) #1;
      chk({sel, rgn, mul, swp, ln, hs, vs}, 32'h0);
      rd_reg(4'h7, 32'h0020DFFF);
      rd_reg(4'h0, 32'h0);
   end
   endtask
   task test_done;
   begin
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      rows[0] = {4'h0, 32'h00057E23};
      rows[1] = {4'h1, 32'h039A8000};
      rows[2] = {4'h2, 32'h02018005};
      rows[3] = {4'h3, 32'h00004001};
      rows[4] = {4'h4, 32'h03FFE003};
      rows[5] = {4'h5, 32'h03FFFFFF};
      rows[6] = {4'h7, 32'h00009FFF};
      rows[7] = {4'hC, 32'h03FFFFFF};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      after_rst;
      for (i = 0; i < 8; i = i + 1)
      begin
         wr_reg(rows[i][35:32], rows[i][31:0]);
         rd_reg(rows[i][35:32], rows[i][35:32] > 4'h9 ? 32'h0 : rows[i][31:0]);
      end
      wr_reg(4'h8, 32'h2);
      wait_sync(1);
      t0 = cyc;
      for (i = 0; i < 4; i = i + 1)
      begin
         repeat (2) @(posedge clk) #1;
         chk({rgn, sel, mul, swp, ln}, {i[3:0], exv[i*7 +: 7], i[12:0]});
         if (i < 3)
            wait_sync(0);
      end
      wait_sync(1);
      chk(cyc - t0, 32'h1805);
      wr_reg(4'h8, 32'h3);
      wait_sync(1);
      t0 = cyc;
      wait_sync(1);
      chk(cyc - t0, 32'h3805);
      wr_reg(4'h0, 32'h00057E3B);
      @(posedge clk) #1;
      chk(sel, 5'h03);
      rd_reg(4'h9, 32'h00020000);
      rd_reg(4'h8, 32'h00000003);
      wait_sync(1);
      repeat (2) @(posedge clk) #1;
      chk(sel, 5'h1B);
      rd_reg(4'h9, 32'h00000000);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      after_rst;
      test_done;
   end
endmodule
